// ---- design/scr_ctrl.v ----
// Serial control register with clock-pin selection, interrupt gating and address-skip reception.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scr_defs.vh"

module scr_ctrl (
  // System
  input  wire        clk_sys,
  input  wire        nrst,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Shifter side events and requests
  input  wire        tx_empty_evt,
  input  wire        rx_full_evt,
  input  wire        rx_err_evt,
  input  wire        tx_end_evt,
  input  wire        frame_done,
  input  wire        frame_addr_bit,
  input  wire        frame_err,
  input  wire        bit_rate_tick,
  // Gated outputs to the shifters and interrupt controller
  output wire        tx_empty_irq,
  output wire        rx_full_irq,
  output wire        rx_err_irq,
  output wire        tx_end_irq,
  output wire        tx_run,
  output wire        rx_run,
  output wire        use_ext_clk,
  output reg         ext_clk_edge,
  // Received-frame flag sets
  output reg         rx_full_flag_set,
  output reg         frame_err_flag_set,
  output reg         overrun_flag_set,
  input  wire        rx_full_flag,
  // Serial clock pin
  input  wire        sck_in,
  output reg         sck_out,
  output reg         sck_oe
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] ser_ctrl_reg_q;
  reg [3:0] mode_q;
  reg       aw_hold_q;
  reg [3:0] aw_addr_q;
  reg       w_hold_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg       sck_s1_q;
  reg       sck_s2_q;
  reg       sck_s3_q;
  reg       clk_div_q;
  // The divider halves the bit-rate tick, which gives the pin clock a
  // balanced duty cycle.

  wire card_mode_sel   = mode_q[`SCR_M_CARD];
  wire gsm_variant     = mode_q[`SCR_M_GSM];
  wire sync_mode       = mode_q[`SCR_M_SYNC];
  wire addr_bit_format = mode_q[`SCR_M_ADDR_FMT];
  wire [1:0] clk_sel   = {ser_ctrl_reg_q[`SCR_CLK_SEL_HI], ser_ctrl_reg_q[`SCR_CLK_SEL_LO]};

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are captured independently so either may come first.
  // Ready drops while a response waits, so a second write cannot overwrite
  // the held address before the first one has been answered.
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire wr_ctrl = wr_go && (aw_addr_q == `SCR_OFS_CTRL) && w_strb_q[0];
  wire wr_mode = wr_go && (aw_addr_q == `SCR_OFS_MODE) && w_strb_q[0];
  wire wr_ok = (aw_addr_q == `SCR_OFS_CTRL) || (aw_addr_q == `SCR_OFS_MODE) ||
               (aw_addr_q == `SCR_OFS_STAT);

  // skip only in async with address format
  wire skip_active = ser_ctrl_reg_q[`SCR_ADDR_SKIP_ON] && addr_bit_format && !sync_mode;
  wire skip_clear = skip_active && frame_done && frame_addr_bit;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_hold_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SCR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SCR_RESP_OKAY : `SCR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ser_ctrl_reg_q <= `SCR_CTRL_RESET;
      mode_q         <= `SCR_MODE_RESET;
    end else begin
      // clock select writable at any time
      // A software write on the same edge as an address frame wins, since
      // the written value is the newer intent.
      if (wr_ctrl) begin
        ser_ctrl_reg_q <= w_data_q[7:0];
      end else if (skip_clear) begin
        ser_ctrl_reg_q[`SCR_ADDR_SKIP_ON] <= 1'b0;
      end
      if (wr_mode) begin
        mode_q <= w_data_q[3:0];
      end
    end
  end

  // Status word: skip state, synchronised clock pin level and receive flag.
  // Software can poll the skip state here to see when an address frame
  // has arrived without enabling any interrupt.
  wire [31:0] stat_word = {29'h0000_0000, rx_full_flag, sck_s2_q, skip_active};

  // Unmapped offsets answer with an error and zero data, so a wrong address
  // in software cannot be mistaken for a cleared register.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SCR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `SCR_RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        `SCR_OFS_CTRL: s_axi_rdata <= {24'h00_0000, ser_ctrl_reg_q};
        `SCR_OFS_MODE: s_axi_rdata <= {28'h000_0000, mode_q};
        `SCR_OFS_STAT: s_axi_rdata <= stat_word;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SCR_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt gating and enables
  // ----------------------------------------------------------------
  // The gates are combinational so that a pending request reaches the
  // interrupt controller in the same cycle as its enable.
  // transmit-empty gate
  assign tx_empty_irq = tx_empty_evt && ser_ctrl_reg_q[`SCR_TX_IRQ_ON];
  assign rx_full_irq  = rx_full_evt && ser_ctrl_reg_q[`SCR_RX_IRQ_ON];
  assign rx_err_irq   = rx_err_evt && ser_ctrl_reg_q[`SCR_RX_IRQ_ON];
  assign tx_end_irq   = tx_end_evt && ser_ctrl_reg_q[`SCR_TXDONE_IRQ_ON];
  assign tx_run = ser_ctrl_reg_q[`SCR_TX_ON];
  assign rx_run = ser_ctrl_reg_q[`SCR_RX_ON];

  // ----------------------------------------------------------------
  // Received-frame flag control
  // ----------------------------------------------------------------
  // Flags are registered one cycle after the frame ends.
  // software keeps skip off in card mode, so no card check here.
  // A frame that ends while the flag is still full reports an overrun
  // instead of a second full event.
  reg  rx_full_set_d;
  reg  overrun_set_d;
  reg  frame_err_set_d;
  wire frame_taken = frame_done && rx_run && !(skip_active && !frame_addr_bit);

  always @* begin
    rx_full_set_d   = 1'b0;
    overrun_set_d   = 1'b0;
    frame_err_set_d = 1'b0;
    if (frame_taken) begin
      rx_full_set_d   = !rx_full_flag;
      overrun_set_d   = rx_full_flag;
      frame_err_set_d = frame_err;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_full_flag_set   <= 1'b0;
      frame_err_flag_set <= 1'b0;
      overrun_flag_set   <= 1'b0;
    end else begin
      rx_full_flag_set   <= rx_full_set_d;
      frame_err_flag_set <= frame_err_set_d;
      overrun_flag_set   <= overrun_set_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial clock pin
  // ----------------------------------------------------------------
  // The external clock is only forwarded as single-cycle rising edges;
  // dividing the sixteenfold clock down to the bit rate is the shifter's
  // job. The pin must stay below half the system clock rate, or edges are
  // lost in the synchroniser.
  // external clock from pin, synchronised
  // synchronous external clock is an input
  assign use_ext_clk = clk_sel[1] && !card_mode_sel;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sck_s1_q     <= 1'b0;
      sck_s2_q     <= 1'b0;
      sck_s3_q     <= 1'b0;
      ext_clk_edge <= 1'b0;
      clk_div_q    <= 1'b0;
    end else begin
      sck_s1_q     <= sck_in;
      sck_s2_q     <= sck_s1_q;
      sck_s3_q     <= sck_s2_q;
      ext_clk_edge <= use_ext_clk && sck_s2_q && !sck_s3_q;
      if (bit_rate_tick) begin
        clk_div_q <= !clk_div_q;
      end
    end
  end

  // The pin is worked out combinationally and registered once, so a
  // select change in GSM operation reaches the pin one edge later and
  // never glitches between two levels.
  reg sck_out_d;
  reg sck_oe_d;

  always @* begin
    sck_out_d = 1'b0;
    sck_oe_d  = 1'b0;
    if (card_mode_sel) begin
      if (gsm_variant) begin
        sck_oe_d = 1'b1;
        case (clk_sel)
          2'b00: begin
            sck_out_d = 1'b0;
          end
          2'b10: begin
            sck_out_d = 1'b1;
          end
          default: begin
            sck_out_d = clk_div_q;
          end
        endcase
      end else begin
        // reserved values leave pin as port
        sck_oe_d  = (clk_sel == 2'b01);
        sck_out_d = (clk_sel == 2'b01) ? clk_div_q : 1'b0;
      end
    end else if (sync_mode) begin
      sck_oe_d  = !clk_sel[1];
      sck_out_d = clk_sel[1] ? 1'b0 : clk_div_q;
    end else begin
      sck_oe_d  = (clk_sel == 2'b01);
      sck_out_d = (clk_sel == 2'b01) ? clk_div_q : 1'b0;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sck_out <= 1'b0;
      sck_oe  <= 1'b0;
    end else begin
      sck_out <= sck_out_d;
      sck_oe  <= sck_oe_d;
    end
  end

endmodule
`default_nettype wire

// ---- shared/scr_defs.vh ----
// Register offsets, field positions and constants of the serial control register block.
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define SCR_OFS_CTRL        4'h0
`define SCR_OFS_MODE        4'h4
`define SCR_OFS_STAT        4'h8

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SCR_TX_IRQ_ON       7
`define SCR_RX_IRQ_ON       6
`define SCR_TX_ON           5
`define SCR_RX_ON           4
`define SCR_ADDR_SKIP_ON    3
`define SCR_TXDONE_IRQ_ON   2
`define SCR_CLK_SEL_HI      1
`define SCR_CLK_SEL_LO      0
`define SCR_CTRL_RESET      8'h00

// ----------------------------------------------------------------
// Mode register fields (own register)
// ----------------------------------------------------------------
`define SCR_M_SYNC          0
`define SCR_M_ADDR_FMT      1
`define SCR_M_GSM           2
`define SCR_M_CARD          3
`define SCR_MODE_RESET      4'h0

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define SCR_RESP_OKAY       2'h0
`define SCR_RESP_SLVERR     2'h2

`endif

// ---- dv/scr_ctrl_props.sv ----
// Port checker for the serial control register block.
`timescale 1ns/1ps
`default_nettype none
module scr_ctrl_props (
  // System
  input wire logic clk_sys,
  input wire logic nrst,
  // Requests and gated interrupts
  input wire logic tx_empty_evt,
  input wire logic rx_full_evt,
  input wire logic rx_err_evt,
  input wire logic tx_empty_irq,
  input wire logic rx_full_irq,
  input wire logic rx_err_irq,
  // Frame path
  input wire logic frame_done,
  input wire logic frame_err,
  input wire logic rx_full_flag,
  input wire logic rx_run,
  input wire logic rx_full_flag_set,
  input wire logic frame_err_flag_set,
  input wire logic overrun_flag_set,
  // Clock pin
  input wire logic use_ext_clk,
  input wire logic ext_clk_edge
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_txe_irq_gate: assert property (tx_empty_irq |-> tx_empty_evt)
    else $error("tx empty irq without request");
  a_rx_irq_pair: assert property (rx_full_evt && rx_err_evt |-> rx_full_irq == rx_err_irq)
    else $error("rx irqs gated apart");
  a_rx_off_quiet: assert property (frame_done && !rx_run |=> !(rx_full_flag_set || overrun_flag_set))
    else $error("flag set with receiver off");
  a_full_set_cause: assert property (rx_full_flag_set |-> $past(frame_done && rx_run && !rx_full_flag))
    else $error("full set without frame");
  a_ovr_set_cause: assert property (overrun_flag_set |-> $past(frame_done && rx_full_flag))
    else $error("overrun set without cause");
  a_ferr_set_cause: assert property (frame_err_flag_set |-> $past(frame_done && frame_err))
    else $error("frame error set without cause");
  a_ext_edge_sel: assert property (ext_clk_edge |-> $past(use_ext_clk))
    else $error("edge with internal clock");
  a_ext_edge_pulse: assert property (ext_clk_edge |=> !ext_clk_edge)
    else $error("edge pulse too long");
  c_frame: cover property (frame_done && rx_run);
  c_ovr: cover property (overrun_flag_set);
  c_edge: cover property (ext_clk_edge);
endmodule
`default_nettype wire

// ---- dv/scr_remote.sv ----
// Remote serial device model driving the serial clock pin.
`timescale 1ns/1ps
`default_nettype none
module scr_remote (
  // Serial clock pin
  output var logic sck_drv
);
  initial sck_drv = 1'b0;
  task automatic burst(input int n);
    repeat (n) begin
      #24 sck_drv = 1'b1;
      #24 sck_drv = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the serial control register block.
`timescale 1ns/1ps
`default_nettype none
`include "scr_defs.vh"
module tb_top;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0, nrst = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, tx_empty_evt = 1'b0, rx_full_evt = 1'b0, rx_err_evt = 1'b0;
  logic        tx_end_evt = 1'b0, frame_done = 1'b0, frame_addr_bit = 1'b0, frame_err = 1'b0;
  logic        bit_rate_tick = 1'b0, rx_full_flag = 1'b0, tx_empty_irq, rx_full_irq, rx_err_irq, tx_end_irq;
  logic        tx_run, rx_run, use_ext_clk, ext_clk_edge, rx_full_flag_set, frame_err_flag_set;
  logic        overrun_flag_set, sck_out, sck_oe, rem_sck;
  wire         sck_in = sck_oe ? sck_out : rem_sck;
  int          error_cnt = 0, cmp_count = 0, edge_cnt = 0;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    bit_rate_tick <= ~bit_rate_tick;
    if (ext_clk_edge === 1'b1)
      edge_cnt <= edge_cnt + 1;
  end
  scr_ctrl u_scr_ctrl (.*);
  scr_remote u_scr_remote (.sck_drv(rem_sck));
  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus tasks hold each channel until its own handshake edge.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) begin error_cnt++; stop_test(); end
    @(posedge clk_sys);
  endtask
  task automatic rdr(input logic [3:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) begin error_cnt++; stop_test(); end
    @(posedge clk_sys);
  endtask
  task automatic frame(input logic a, input logic e, input logic [2:0] x, input string nm);
    frame_done <= 1'b1;
    frame_addr_bit <= a;
    frame_err <= e;
    @(posedge clk_sys);
    frame_done <= 1'b0;
    #1;
    chk(nm, x, {rx_full_flag_set, overrun_flag_set, frame_err_flag_set});
    @(posedge clk_sys);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdr(`SCR_OFS_CTRL);
    chk("ctrl reset", {24'h0, `SCR_CTRL_RESET}, rd);
    wr(4'hC, 32'hFF);
    chk("bad wr", `SCR_RESP_SLVERR, rs);
    rdr(4'hC);
    chk("bad rd", `SCR_RESP_SLVERR, rs);
  endtask
  task automatic t_irq();
    logic [7:0] v;
    {tx_empty_evt, rx_full_evt, rx_err_evt, tx_end_evt} <= 4'hF;
    for (int b = 2; b < 8; b++) begin
      v = 8'h01 << b;
      wr(`SCR_OFS_CTRL, {24'h0, v});
      rdr(`SCR_OFS_CTRL);
      chk("ctrl rw", {24'h0, v}, rd);
      chk("gates", {v[7], v[6], v[6], v[2], v[5], v[4]},
          {tx_empty_irq, rx_full_irq, rx_err_irq, tx_end_irq, tx_run, rx_run});
    end
  endtask
  task automatic t_skip();
    wr(`SCR_OFS_CTRL, 32'h0);
    wr(`SCR_OFS_MODE, 32'h2);
    chk("wr resp", `SCR_RESP_OKAY, rs);
    frame(1'b1, 1'b0, 3'b000, "rx off");
    wr(`SCR_OFS_CTRL, 32'h18);
    rdr(`SCR_OFS_STAT);
    chk("stat skip", 32'h1, rd);
    chk("rd resp", `SCR_RESP_OKAY, rs);
    frame(1'b0, 1'b1, 3'b000, "skipped");
    frame(1'b1, 1'b0, 3'b100, "addr frame");
    rdr(`SCR_OFS_CTRL);
    chk("skip clear", 32'h10, rd);
    rx_full_flag <= 1'b1;
    wr(`SCR_OFS_MODE, 32'h3);
    wr(`SCR_OFS_CTRL, 32'h18);
    frame(1'b0, 1'b1, 3'b011, "sync skip");
    rx_full_flag <= 1'b0;
  endtask
  task automatic t_clk();
    logic [7:0] rows [12] = '{8'h00, 8'h06, 8'h09, 8'h12, 8'h19, 8'h80, 8'h86, 8'h88, 8'hC2, 8'hCA, 8'hC6, 8'hCE};
    logic lv, tg;
    foreach (rows[i]) begin
      wr(`SCR_OFS_MODE, {28'h0, rows[i][7:4]});
      wr(`SCR_OFS_CTRL, {30'h0, rows[i][3:2]});
      repeat (2) @(posedge clk_sys);
      #1;
      chk("pin mode", rows[i][1:0], {sck_oe, use_ext_clk});
      lv = sck_out;
      tg = 1'b0;
      repeat (8) begin
        @(posedge clk_sys);
        #1;
        tg = tg | (sck_out !== lv);
        lv = sck_out;
      end
      if (rows[i][7:6] == 2'b11 && !rows[i][2])
        chk("pin level", rows[i][3], sck_out);
      else if (rows[i][1])
        chk("pin clock", 1'b1, tg);
    end
  endtask
  task automatic t_ext(input logic [31:0] m, input logic [31:0] c, input int n, input int x);
    int e0;
    wr(`SCR_OFS_MODE, m);
    wr(`SCR_OFS_CTRL, c);
    e0 = edge_cnt;
    u_scr_remote.burst(n);
    repeat (8) @(posedge clk_sys);
    chk("ext edges", x, edge_cnt - e0);
  endtask
  task automatic t_rerun();
    wr(`SCR_OFS_CTRL, 32'hFF);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rdr(`SCR_OFS_CTRL);
    chk("ctrl rerun", {24'h0, `SCR_CTRL_RESET}, rd);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_irq();
    t_skip();
    t_clk();
    t_ext(32'h0, 32'h2, 6, 6);
    t_ext(32'h1, 32'h2, 3, 3);
    t_ext(32'h0, 32'h1, 3, 0);
    t_rerun();
    stop_test();
  end
endmodule
bind scr_ctrl scr_ctrl_props u_scr_ctrl_props (.*);
`default_nettype wire
